// [bench/rbpw_chk.sv]
// port checker for the region bus controller
`timescale 1ns/1ns
module rbpw_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic core_req,
    input wire logic core_ready,
    input wire logic core_done,
    input wire logic core_fault,
    input wire logic bus_ads_n,
    input wire logic bus_den_n,
    input wire logic bus_blast_n,
    input wire logic [3:0] bus_be_n,
    input wire logic parity_fail_out_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic seen_q;
    // remembers a pin pulse until the access completes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            seen_q <= 1'b0;
        else if (core_done)
            seen_q <= 1'b0;
        else if (!parity_fail_out_n)
            seen_q <= 1'b1;
    end
    sequence s_take;
        core_req && core_ready;
    endsequence
    sequence s_addr;
        !bus_ads_n;
    endsequence
    pin_pulse_a: assert property (!parity_fail_out_n |=> parity_fail_out_n) else $error("pin pulse long");
    pin_fault_a: assert property (core_done && core_fault |-> seen_q || !parity_fail_out_n)
        else $error("fault without pin");
    no_fault_a: assert property (core_done && !core_fault |-> !seen_q && parity_fail_out_n)
        else $error("pin without fault");
    pin_done_a: assert property (!parity_fail_out_n |-> ##[0:300] (core_done && core_fault))
        else $error("fault not reported");
    take_addr_a: assert property (s_take |=> s_addr) else $error("no address phase");
    wait_floor_a: assert property (s_addr |=> !core_done [*2]) else $error("data too early");
    ads_single_a: assert property (s_addr |=> bus_ads_n) else $error("address phase long");
    ads_den_a: assert property (s_addr |-> !bus_den_n) else $error("den off in address");
    blast_den_a: assert property (!bus_blast_n |-> !bus_den_n) else $error("last without den");
    done_ready_a: assert property (core_done |=> core_ready) else $error("not ready after done");
    be_lane_a: assert property (s_addr |-> bus_be_n != 4'hF) else $error("beat without wanted lane");
    be_idle_a: assert property (core_ready |-> bus_be_n == 4'hF) else $error("lanes enabled while idle");
endmodule : rbpw_chk

bind rbpw_ctrl rbpw_chk u_rbpw_chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .core_req(core_req),
    .core_ready(core_ready),
    .core_done(core_done),
    .core_fault(core_fault),
    .bus_ads_n(bus_ads_n),
    .bus_den_n(bus_den_n),
    .bus_blast_n(bus_blast_n),
    .bus_be_n(bus_be_n),
    .parity_fail_out_n(parity_fail_out_n)
);

// [bench/rbpw_ctrl_tb.sv]
// self-checking bench of the region bus controller
`timescale 1ns/1ns
module rbpw_ctrl_tb;
    import rbpw_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic f;} rbpw_exp_t;
    logic sys_clk, rst, reg_wr, reg_rd, core_req, core_ready, core_done, core_fault;
    logic bus_ads_n, bus_blast_n, bus_den_n, ready_n, parity_fail_out_n, use_rdy, bad_par, rd_q;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, core_addr, core_rdata, bus_addr, bus_data, a;
    logic [1:0]  core_size;
    logic [3:0]  core_type, bus_be_n, bus_par, ty;
    rbpw_exp_t   core_q[$], reg_q[$], e;
    int mismatches = 0, tests_run = 0, cyc = 0, l0, l1;

    rbpw_ctrl u_rbpw_ctrl (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_req(core_req), .core_addr(core_addr),
        .core_size(core_size), .core_type(core_type), .core_ready(core_ready), .core_done(core_done),
        .core_rdata(core_rdata), .core_fault(core_fault), .bus_addr(bus_addr), .bus_ads_n(bus_ads_n),
        .bus_blast_n(bus_blast_n), .bus_den_n(bus_den_n), .bus_be_n(bus_be_n), .bus_data(bus_data),
        .bus_par(bus_par), .ready_n(ready_n), .parity_fail_out_n(parity_fail_out_n));
    rbpw_mem u_rbpw_mem (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_ads_n(bus_ads_n), .bus_den_n(bus_den_n),
        .use_rdy(use_rdy), .bad_par(bad_par), .bus_data(bus_data), .bus_par(bus_par), .ready_n(ready_n));

    always #25 sys_clk = ~sys_clk;

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
        tests_run++;
        if (s !== ex) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, ex, s);
        end
    endtask : chk

    // region configuration word from its fields
    function automatic logic [31:0] cfg(input int read_addr_to_data_waits, read_data_to_data_waits, w, bu, pi, pa, ca, rdy);
        cfg = {9'h0, 1'(rdy), 1'(ca), 1'(pa), 1'(pi), 1'(bu), 2'(w), 8'h0, 3'(read_data_to_data_waits), 5'(read_addr_to_data_waits)};
    endfunction : cfg

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] m);
        reg_q.push_back('{ex, m, 1'b0});
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask : rd

    // one core read; notes the bytes expected and returns the cycles to completion
    task automatic core(input logic [31:0] ad, input logic [1:0] sz, input logic [3:0] t, input logic fl,
                        input logic ca, output int lat);
        logic [31:0] b;
        logic [31:0] w;
        int n;
        n = (sz == 2'h0) ? 1 : (sz == 2'h1) ? 2 : 4;
        b = ca ? (ad & 32'hFFFFFFFC) : ad;
        n = ca ? 4 : n;
        for (int i = 0; i < 4; i++)
            w[8*i+:8] = (i < n) ? (b[7:0] + 8'(i)) ^ 8'h34 : 8'h00;
        core_q.push_back('{w, (n == 4) ? 32'hFFFFFFFF : (32'h1 << (8 * n)) - 32'h1, fl});
        @(posedge sys_clk);
        core_req <= 1'b1;
        core_addr <= ad;
        core_size <= sz;
        core_type <= t;
        do @(negedge sys_clk); while (core_ready !== 1'b1);
        @(posedge sys_clk);
        core_req <= 1'b0;
        lat = 0;
        do begin
            @(negedge sys_clk);
            lat++;
        end while (core_done !== 1'b1);
    endtask : core

    // watcher: compares each result against the oldest note
    always @(posedge sys_clk) rd_q <= reg_rd;
    always @(negedge sys_clk) begin
        if (core_done === 1'b1) begin
            if (core_q.size() == 0)
                chk("spare_done", 32'h0, 32'h1);
            else begin
                e = core_q.pop_front();
                chk("core_rdata", e.d & e.m, core_rdata & e.m);
                chk("core_fault", {31'h0, e.f}, {31'h0, core_fault});
            end
        end
        if (rd_q === 1'b1 && reg_q.size() != 0) begin
            e = reg_q.pop_front();
            chk("reg_rdata", e.d & e.m, reg_rdata & e.m);
        end
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        {sys_clk, reg_wr, reg_rd, core_req, use_rdy, bad_par, rd_q} = 7'h00;
        {reg_addr, reg_wdata, core_addr, core_size, core_type} = 78'h0;
        rst = 1'b1;
        void'($urandom(32'h4FAEFDD0));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        do @(negedge sys_clk); while (core_ready !== 1'b1);
        rd(8'h3C, 32'h03020100, 32'hFFFFFFFF);
        rd(8'h48, 32'h00000002, 32'h00000002);
        rd(8'h00, 32'h0000001F, 32'hFFFFFFFF);
        rd(8'h80, 32'h00000000, 32'hFFFFFFFF);
        wr(8'h3C, 32'h0012001F);
        rd(8'h3C, 32'h0012001F, 32'hFFFFFFFF);
        // read waits: address-to-data and data-to-data counts each add their cycles
        wr(8'h04, cfg(0, 0, 2, 0, 0, 1, 0, 0));
        core(32'h10000000, 2'h2, 4'h1, 1'b0, 1'b0, l0);
        wr(8'h04, cfg(5, 0, 2, 0, 0, 1, 0, 0));
        core(32'h10000000, 2'h2, 4'h1, 1'b0, 1'b0, l1);
        chk("addr_waits", 32'(l0 + 5), 32'(l1));
        wr(8'h04, cfg(3, 0, 0, 1, 0, 1, 0, 0));
        core(32'h10000010, 2'h2, 4'h1, 1'b0, 1'b0, l0);
        wr(8'h04, cfg(3, 3, 0, 1, 0, 1, 0, 0));
        core(32'h10000010, 2'h2, 4'h1, 1'b0, 1'b0, l1);
        chk("data_waits", 32'(l0 + 9), 32'(l1));
        // ready arrives at once but must wait out the programmed count:
        // address phase, eight waits, capture and done take eleven cycles at the least
        use_rdy <= 1'b1;
        wr(8'h04, cfg(0, 0, 2, 0, 0, 1, 0, 1));
        core(32'h10000000, 2'h2, 4'h1, 1'b0, 1'b0, l0);
        wr(8'h04, cfg(8, 0, 2, 0, 0, 1, 0, 1));
        core(32'h10000000, 2'h2, 4'h1, 1'b0, 1'b0, l1);
        chk("ready_ignored", 32'h1, {31'h0, l1 >= 8 + 3 && l1 > l0});
        // random reads over widths, burst, pipeline, ready and cacheable settings
        for (int i = 0; i < 24; i++) begin
            use_rdy <= (i >= 12);
            wr(8'h08, cfg((i >= 12) ? 4 : $urandom % 2, (i >= 12) ? 3 : 1 + $urandom % 3, i % 3, (i / 3) % 2,
                          (i / 6) % 2, 1, i % 5 == 4, i >= 12));
            a = 32'h20000000 | ($urandom & 32'h000000FF);
            if (i % 2 == 1)
                a[3:0] = 4'hF - 4'($urandom % 3);
            core(a, 2'($urandom % 3), 4'($urandom % 15), 1'b0, i % 5 == 4, l0);
        end
        // bad parity on a narrow unaligned read, then a clean read right behind it
        use_rdy <= 1'b0;
        ty = 4'($urandom % 15);
        wr(8'h0C, cfg(2, 2, 1, 0, 1, 1, 0, 0));
        bad_par <= 1'b1;
        core(32'h30000001, 2'h1, ty, 1'b1, 1'b0, l0);
        bad_par <= 1'b0;
        core(32'h30000008, 2'h0, 4'h2, 1'b0, 1'b0, l0);
        rd(8'h40, 32'h30000001, 32'hFFFFFFFF);
        rd(8'h44, {28'h0, ty}, 32'h0000000F);
        rd(8'h48, 32'h00000001, 32'h00000001);
        wr(8'h48, 32'h00000001);
        rd(8'h48, 32'h00000000, 32'h00000001);
        // parity off in the region: bad parity goes unnoticed
        wr(8'h10, cfg(1, 1, 0, 0, 0, 0, 0, 0));
        bad_par <= 1'b1;
        core(32'h40000003, 2'h0, 4'h3, 1'b0, 1'b0, l0);
        bad_par <= 1'b0;
        rd(8'h48, 32'h00000000, 32'h00000001);
        repeat (3) @(posedge sys_clk);
        finish_test();
    end
endmodule : rbpw_ctrl_tb

// [bench/rbpw_mem.sv]
// behavioural memory on the far side of the region bus
`timescale 1ns/1ns
module rbpw_mem (
    input  wire logic        sys_clk,
    input  wire logic [31:0] bus_addr,
    input  wire logic        bus_ads_n,
    input  wire logic        bus_den_n,
    input  wire logic        use_rdy,
    input  wire logic        bad_par,
    output      logic [31:0] bus_data,
    output      logic [3:0]  bus_par,
    output      logic        ready_n
);
    logic [31:0] alt_q = 32'h5A5A5A5A;
    // lane i holds byte address+i, so the boot byte at the record start reads zero
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bus_data[8*i+:8] = bus_den_n ? alt_q[8*i+:8] : (bus_addr[7:0] + 8'(i)) ^ 8'h34;
            bus_par[i] = ~^bus_data[8*i+:8] ^ bad_par;
        end
    end
    // a released bus toggles; ready answers early in a beat, or never
    always_ff @(posedge sys_clk) begin
        alt_q <= ~alt_q;
        ready_n <= !(use_rdy && !bus_den_n && bus_ads_n);
    end
endmodule : rbpw_mem

// [rtl/rbpw_ctrl.sv]
// region bus controller: wait states, ready, beat splitting, parity and boot load
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`include "rbpw_map.svh"

// Functional notes
// - with parity enabled every failure both pulses the parity pin low and raises a fault, with no separate mask.
// - parity is checked only on reads from regions whose configuration enables it, at any bus width.
// - unaligned halfword reads on narrow buses check only the lanes that carry wanted bytes, so good data never fails.
// - loads from cacheable regions other than boot reads are always issued as aligned full-word loads.
// - a narrow read that crosses a 16-byte boundary continues at the start of the next 16-byte segment.
// - each region holds its own burst and pipeline enables, and both shape how its reads are issued.
// - each region supplies address-to-data and data-to-data read waits that are inserted in those phases.
// - the ready input is ignored while programmed waits run and sampled only after they expire.
// - after reset the region 15 bytes are loaded from the boot record, and software later overwrites them.
// - each boot record byte is stored in its own byte of region 15 with no merging between bytes.
// - a parity fault records the address and type of the faulting access even if another access follows.
module rbpw_ctrl
    import rbpw_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [31:0] reg_rdata,
    // core request port
    input  wire logic        core_req,
    input  wire logic [31:0] core_addr,
    input  wire logic [1:0]  core_size,
    input  wire logic [3:0]  core_type,
    output      logic        core_ready,
    output      logic        core_done,
    output      logic [31:0] core_rdata,
    output      logic        core_fault,
    // external bus
    output      logic [31:0] bus_addr,
    output      logic        bus_ads_n,
    output      logic        bus_blast_n,
    output      logic        bus_den_n,
    output      logic [3:0]  bus_be_n,
    input  wire logic [31:0] bus_data,
    input  wire logic [3:0]  bus_par,
    input  wire logic        ready_n,
    output      logic        parity_fail_out_n
);

    rbpw_state_t state_q;
    logic [31:0] cfg_q [16];
    logic [31:0] acc_addr_q;
    logic [31:0] last_addr_q;
    logic [31:0] beat_addr_q;
    logic [2:0]  acc_nb_q;
    logic [3:0]  acc_type_q;
    logic [4:0]  cnt_q;
    logic        acc_fault_q;
    logic [31:0] rdata_q;
    logic        boot_q;
    logic [1:0]  boot_idx_q;
    logic [31:0] fault_addr_q;
    logic [3:0]  fault_type_q;
    logic        fault_q;
    logic        pfail_n_q;
    logic [31:0] reg_rdata_q;
    logic        rdy_s1_q, rdy_s2_q;
    logic [31:0] data_s1_q, data_s2_q;
    logic [3:0]  par_s1_q, par_s2_q;

    logic [31:0] req_addr, req_a, req_cfg, cur_cfg, next_beat;
    logic [1:0]  req_size;
    logic [3:0]  req_type;
    logic [2:0]  req_nb, req_ub, cur_ub;
    logic        start, more, need_ads, cap, fail;
    logic [4:0]  cur_read_addr_to_data_waits, cur_read_data_to_data_waits;
    logic        cur_burst, cur_pipe, cur_par, cur_ext;
    logic [3:0]  lane_hit, lane_err;
    logic [1:0]  lane_off [4];

    // unit width in bytes for a bus width code
    function automatic logic [2:0] unit_bytes(input logic [1:0] w);
        case (rbpw_width_t'(w))
            RBPW_BUS8:  unit_bytes = 3'h1;
            RBPW_BUS16: unit_bytes = 3'h2;
            default:    unit_bytes = 3'h4;
        endcase
    endfunction : unit_bytes

    // two-stage synchronisers on every bus input
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdy_s1_q  <= 1'b1;
            rdy_s2_q  <= 1'b1;
            data_s1_q <= 32'h00000000;
            data_s2_q <= 32'h00000000;
            par_s1_q  <= 4'h0;
            par_s2_q  <= 4'h0;
        end else begin
            rdy_s1_q  <= ready_n;
            rdy_s2_q  <= rdy_s1_q;
            data_s1_q <= bus_data;
            data_s2_q <= data_s1_q;
            par_s1_q  <= bus_par;
            par_s2_q  <= par_s1_q;
        end
    end

    // request selection: boot reads first, then core requests
    always_comb begin
        req_addr = boot_q ? (`RBPW_IBR_R15_ADDR + {30'h0, boot_idx_q}) : core_addr;
        req_size = boot_q ? `RBPW_SIZE_BYTE : core_size;
        req_type = boot_q ? `RBPW_TYPE_BOOT : core_type;
        req_cfg  = cfg_q[req_addr[31:28]];
        req_ub   = unit_bytes(req_cfg[`RBPW_WIDTH_LSB +: 2]);
        if (req_cfg[`RBPW_CACHE_BIT] && !boot_q) begin
            req_nb = 3'h4;
            req_a  = {req_addr[31:2], 2'b00};
        end else begin
            req_nb = (req_size >= `RBPW_SIZE_WORD) ? 3'h4 : (3'h1 << req_size);
            req_a  = req_addr;
        end
    end

    assign start      = (state_q == RBPW_IDLE) && (boot_q || core_req);
    assign core_ready = (state_q == RBPW_IDLE) && !boot_q;

    // settings of the region being accessed
    assign cur_cfg   = cfg_q[acc_addr_q[31:28]];
    assign cur_ub    = unit_bytes(cur_cfg[`RBPW_WIDTH_LSB +: 2]);
    assign cur_read_addr_to_data_waits  = cur_cfg[`RBPW_READ_ADDR_TO_DATA_WAITS_LSB +: `RBPW_READ_ADDR_TO_DATA_WAITS_W];
    assign cur_read_data_to_data_waits  = {2'b00, cur_cfg[`RBPW_READ_DATA_TO_DATA_WAITS_LSB +: `RBPW_READ_DATA_TO_DATA_WAITS_W]};
    assign cur_burst = cur_cfg[`RBPW_BURST_BIT];
    assign cur_pipe  = cur_cfg[`RBPW_PIPE_BIT];
    assign cur_par   = cur_cfg[`RBPW_PAR_BIT];
    assign cur_ext   = cur_cfg[`RBPW_EXTRDY_BIT];

    // next beat address; a full add carries into the next 16-byte segment
    assign next_beat = beat_addr_q + {29'h0, cur_ub};
    assign more      = next_beat <= last_addr_q;
    assign need_ads  = !cur_burst || (next_beat[31:4] != beat_addr_q[31:4]);

    // beat capture: after waits, on synced ready or after the settle time
    assign cap = ((state_q == RBPW_WAIT) && (cnt_q == 5'h00) && cur_ext && !rdy_s2_q)
              || ((state_q == RBPW_SETTLE) && (cnt_q == 5'h00));

    // lanes of this beat that carry wanted bytes, and their place in the result
    for (genvar i = 0; i < 4; i++) begin : g_lane
        logic [31:0] off;
        assign off         = beat_addr_q + 32'(i) - acc_addr_q;
        assign lane_hit[i] = (3'(i) < cur_ub) && (off < {29'h0, acc_nb_q});
        assign lane_off[i] = off[1:0];
    end

    rbpw_parity #(
        .LANES (4),
        .ODD   (1'b1)
    ) u_parity (
        .data     (data_s2_q),
        .par      (par_s2_q),
        .lane_err (lane_err)
    );

    // parity failure only for enabled regions and only on wanted lanes
    assign fail = cap && cur_par && |(lane_err & lane_hit);

    // access sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q     <= RBPW_IDLE;
            acc_addr_q  <= 32'h00000000;
            last_addr_q <= 32'h00000000;
            beat_addr_q <= 32'h00000000;
            acc_nb_q    <= 3'h0;
            acc_type_q  <= 4'h0;
            cnt_q       <= 5'h00;
        end else begin
            case (state_q)
                RBPW_IDLE: begin
                    if (start) begin
                        acc_addr_q  <= req_a;
                        acc_nb_q    <= req_nb;
                        acc_type_q  <= req_type;
                        last_addr_q <= req_a + {29'h0, req_nb} - 32'h00000001;
                        beat_addr_q <= req_a & ~{29'h0, req_ub - 3'h1};
                        state_q     <= RBPW_ADDR;
                    end
                end
                RBPW_ADDR: begin
                    cnt_q   <= cur_read_addr_to_data_waits;
                    state_q <= RBPW_WAIT;
                end
                RBPW_WAIT: begin
                    if (cnt_q != 5'h00) begin
                        cnt_q <= cnt_q - 5'h01;
                    end else if (!cur_ext) begin
                        cnt_q   <= `RBPW_SETTLE_CNT;
                        state_q <= RBPW_SETTLE;
                    end
                end
                RBPW_SETTLE: begin
                    if (cnt_q != 5'h00) begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                RBPW_GAP: begin
                    state_q <= RBPW_ADDR;
                end
                RBPW_DONE: begin
                    state_q <= RBPW_IDLE;
                end
                default: begin
                    state_q <= RBPW_IDLE;
                end
            endcase
            // after a beat: next beat in burst, new address, or finish
            if (cap) begin
                if (more) begin
                    beat_addr_q <= next_beat;
                    if (need_ads) begin
                        state_q <= cur_pipe ? RBPW_ADDR : RBPW_GAP;
                    end else begin
                        cnt_q   <= cur_read_data_to_data_waits;
                        state_q <= RBPW_WAIT;
                    end
                end else begin
                    state_q <= RBPW_DONE;
                end
            end
        end
    end

    // read data assembly and fault flag of the running access
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q     <= 32'h00000000;
            acc_fault_q <= 1'b0;
        end else if (start) begin
            rdata_q     <= 32'h00000000;
            acc_fault_q <= 1'b0;
        end else if (cap) begin
            for (int i = 0; i < 4; i++) begin
                if (lane_hit[i]) begin
                    rdata_q[8*lane_off[i] +: 8] <= data_s2_q[8*i +: 8];
                end
            end
            if (fail) begin
                acc_fault_q <= 1'b1;
            end
        end
    end

    // boot load of region 15 and software writes to the region table
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int r = 0; r < 16; r++) begin
                cfg_q[r] <= `RBPW_REGION_RST;
            end
            boot_q     <= 1'b1;
            boot_idx_q <= 2'h0;
        end else begin
            if (boot_q && state_q == RBPW_DONE) begin
                cfg_q[`RBPW_BOOT_REGION][8*boot_idx_q +: 8] <= rdata_q[7:0];
                boot_idx_q <= boot_idx_q + 2'h1;
                if (boot_idx_q == `RBPW_BOOT_BYTES) begin
                    boot_q <= 1'b0;
                end
            end
            if (reg_wr && reg_addr[7:6] == 2'b00) begin
                cfg_q[reg_addr[5:2]] <= reg_wdata;
            end
        end
    end

    // fault record, sticky flag and parity pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_addr_q <= 32'h00000000;
            fault_type_q <= 4'h0;
            fault_q      <= 1'b0;
            pfail_n_q    <= 1'b1;
        end else begin
            pfail_n_q <= !fail;
            if (fail) begin
                fault_addr_q <= acc_addr_q;
                fault_type_q <= acc_type_q;
                fault_q      <= 1'b1;
            end else if (reg_wr && reg_addr == `RBPW_STATUS_OFS && reg_wdata[`RBPW_ST_FAULT_BIT]) begin
                fault_q <= 1'b0;
            end
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr[7:6] == 2'b00) begin
                reg_rdata_q <= cfg_q[reg_addr[5:2]];
            end else begin
                case (reg_addr)
                    `RBPW_FAULT_ADDR_OFS: reg_rdata_q <= fault_addr_q;
                    `RBPW_FAULT_TYPE_OFS: reg_rdata_q <= {28'h0000000, fault_type_q};
                    `RBPW_STATUS_OFS:     reg_rdata_q <= {29'h0, state_q != RBPW_IDLE, !boot_q, fault_q};
                    default:              reg_rdata_q <= 32'h00000000;
                endcase
            end
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end

    // bus and core outputs
    assign reg_rdata         = reg_rdata_q;
    assign core_done         = (state_q == RBPW_DONE) && !boot_q;
    assign core_rdata        = rdata_q;
    assign core_fault        = acc_fault_q;
    assign bus_addr          = beat_addr_q;
    assign bus_ads_n         = !(state_q == RBPW_ADDR);
    assign bus_den_n         = !(state_q == RBPW_ADDR || state_q == RBPW_WAIT || state_q == RBPW_SETTLE);
    assign bus_blast_n       = !((state_q == RBPW_WAIT || state_q == RBPW_SETTLE) && (!more || need_ads));
    assign bus_be_n          = (state_q == RBPW_IDLE) ? 4'hF : ~lane_hit;
    assign parity_fail_out_n = pfail_n_q;

endmodule : rbpw_ctrl

// [rtl/rbpw_map.svh]
// register offsets, field positions, reset values and counts of the region bus controller
`ifndef RBPW_MAP_SVH
`define RBPW_MAP_SVH

// register byte offsets
`define RBPW_CFG_BASE       8'h00
`define RBPW_FAULT_ADDR_OFS 8'h40
`define RBPW_FAULT_TYPE_OFS 8'h44
`define RBPW_STATUS_OFS     8'h48

// region configuration word fields
`define RBPW_READ_ADDR_TO_DATA_WAITS_LSB       0
`define RBPW_READ_ADDR_TO_DATA_WAITS_W         5
`define RBPW_READ_DATA_TO_DATA_WAITS_LSB       5
`define RBPW_READ_DATA_TO_DATA_WAITS_W         3
`define RBPW_WIDTH_LSB      16
`define RBPW_BURST_BIT      18
`define RBPW_PIPE_BIT       19
`define RBPW_PAR_BIT        20
`define RBPW_CACHE_BIT      21
`define RBPW_EXTRDY_BIT     22

// status register bits
`define RBPW_ST_FAULT_BIT   0
`define RBPW_ST_BOOT_BIT    1
`define RBPW_ST_BUSY_BIT    2

// reset value of every region: 8-bit bus, 31 address-to-data waits, no data-to-data waits, no ready
`define RBPW_REGION_RST     32'h0000001F

// boot record location of region 15 configuration bytes 0..3
`define RBPW_IBR_R15_ADDR   32'hFEFFFF34
`define RBPW_BOOT_REGION    4'hF
`define RBPW_BOOT_BYTES     2'h3

// access sizes and types
`define RBPW_SIZE_BYTE      2'h0
`define RBPW_SIZE_WORD      2'h2
`define RBPW_TYPE_BOOT      4'hF

// cycles to let bus data pass the two-stage input synchroniser
`define RBPW_SETTLE_CNT     5'h01

`endif

// [rtl/rbpw_parity.sv]
// per-lane parity checker of the region bus controller
`timescale 1ns/1ns
module rbpw_parity
    import rbpw_pkg::*;
#(
    parameter int  LANES = 4,
    parameter bit  ODD   = 1'b1
) (
    input  wire logic [8*LANES-1:0] data,
    input  wire logic [LANES-1:0]   par,
    output      logic [LANES-1:0]   lane_err
);

    // a lane is in error when its byte and parity bit disagree with the chosen sense
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign lane_err[i] = ((^data[8*i +: 8]) ^ par[i]) != ODD;
    end

endmodule : rbpw_parity

// [rtl/rbpw_pkg.sv]
// types of the region bus controller
package rbpw_pkg;

    typedef enum logic [2:0] {
        RBPW_IDLE   = 3'b000,
        RBPW_ADDR   = 3'b001,
        RBPW_WAIT   = 3'b010,
        RBPW_SETTLE = 3'b011,
        RBPW_GAP    = 3'b100,
        RBPW_DONE   = 3'b101
    } rbpw_state_t;

    typedef enum logic [1:0] {
        RBPW_BUS8  = 2'b00,
        RBPW_BUS16 = 2'b01,
        RBPW_BUS32 = 2'b10
    } rbpw_width_t;

endpackage : rbpw_pkg
